// *** isse_regs.vh ***
`ifndef ISSE_REGS_VH
`define ISSE_REGS_VH
`define ISSE_CLK_NS            8
`define ISSE_DATA_W            8
`define ISSE_FIFO_DEPTH        16
`define ISSE_FIFO_AW           4
`define ISSE_BIT_CNT_W         3
`define ISSE_BIT_LAST          3'h7
`define ISSE_RESET_LOW_TO_IO_RELEASE_MIN_CYC 1
`define ISSE_RESET_LOW_TO_IO_RELEASE_MAX_CYC 2
`define ISSE_STARTUP_TIMEOUT_US 100
`define ISSE_STARTUP_TIMEOUT_CYC ((`ISSE_STARTUP_TIMEOUT_US * 1000) / `ISSE_CLK_NS)
`define ISSE_PWR_CNT_W         14
`endif

// *** isse_fifo.v ***
`timescale 1ns/1ps
module isse_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr;
  reg [AW:0]      rdPtr;
  wire            empty;
  wire            full;
  assign empty    = (wrPtr == rdPtr);
  assign full     = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem[rdPtr[AW-1:0]];
  always @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule // isse_fifo

// *** isse_isp_serial_entry_exit_sequencer.v ***
// Functional notes
// - gpio-reset or disabled: power-up entry only
// - io tristated one to two clocks; the code takes three clocks from the pin
// - programmer is master, device is slave
// - bytes shift msb first, fixed order
// - mode zero: rise samples, fall changes
// - fuse changes apply after session ends
`timescale 1ns/1ps
`include "isse_regs.vh"
module isse_isp_serial_entry_exit_sequencer (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // device pins
  input  wire       rstPin,
  input  wire       selectPin,
  input  wire       sck,
  input  wire       mosi,
  output reg        miso,
  output reg        misoOe_n,
  output reg        ioRelease,
  // stored settings, read by the fuse row
  input  wire       resetPinEnableFuse,
  input  wire       programEnableFuse,
  // received bytes to the programming engine
  output wire       rxValid,
  input  wire       rxReady,
  output wire [7:0] rxData,
  // reply byte from the programming engine
  input  wire [7:0] txData,
  input  wire       txLoad,
  // status
  output reg        programming,
  output reg        rxOverrun
);
  localparam ST_RUN    = 4'h1;
  localparam ST_WAIT   = 4'h2;
  localparam ST_PROG   = 4'h4;
  localparam ST_EXIT   = 4'h8;
  // session decode is shared by the status flop, the pin enable and the shifter
  function in_session;
    input [3:0] s;
    begin
      in_session = (s == ST_PROG);
    end
  endfunction
  reg [1:0] rstSync;
  reg [1:0] selSync;
  reg [2:0] sckSync;
  reg [1:0] mosiSync;
  reg [3:0] state;
  reg [3:0] next_state;
  reg       resetPinEnable;
  reg       programEnable;
  reg       powerUp;
  reg [`ISSE_PWR_CNT_W-1:0] porCnt;
  reg [2:0] bitCnt;
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  reg       pushValid;
  reg [7:0] pushData;
  wire      pushReady;
  wire      rstLow;
  wire      selHigh;
  wire      sckRise;
  wire      sckFall;
  wire      entryAllowed;
  assign rstLow  = ~rstSync[1];
  assign selHigh = selSync[1];
  assign sckRise = sckSync[1] & ~sckSync[2];
  assign sckFall = ~sckSync[1] & sckSync[2];
  // a running entry needs both the reset pin and the programming setting
  assign entryAllowed = powerUp | (resetPinEnable & programEnable);
  always @(posedge clk) begin
    if (!reset_n) begin
      rstSync  <= 2'h0;
      selSync  <= 2'h0;
      sckSync  <= 3'h0;
      mosiSync <= 2'h0;
    end else begin
      rstSync  <= {rstSync[0], rstPin};
      selSync  <= {selSync[0], selectPin};
      sckSync  <= {sckSync[1:0], sck};
      mosiSync <= {mosiSync[0], mosi};
    end
  end
  // settings latch only while not programming, so edits apply after reset rises
  always @(posedge clk) begin
    if (!reset_n) begin
      resetPinEnable <= 1'b1;
      programEnable  <= 1'b1;
      powerUp        <= 1'b1;
      porCnt         <= `ISSE_PWR_CNT_W'h0;
    end else begin
      if (state == ST_RUN && !rstLow) begin
        resetPinEnable <= resetPinEnableFuse;
        programEnable  <= programEnableFuse;
      end
      // entry while this counter runs counts as power-up entry, whatever the settings
      if (powerUp) begin
        if (porCnt == `ISSE_STARTUP_TIMEOUT_CYC - 1) begin
          powerUp <= 1'b0;
        end else begin
          porCnt <= porCnt + 1'b1;
        end
      end
    end
  end
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (rstLow && entryAllowed) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!rstLow) begin
          next_state = ST_RUN;
        end else if (selHigh) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (!rstLow) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      state       <= ST_RUN;
      ioRelease   <= 1'b1;
      programming <= 1'b0;
    end else begin
      state       <= next_state;
      // two sync stages plus this flop put release three clocks after the pin
      ioRelease   <= rstLow | powerUp;
      programming <= in_session(next_state);
    end
  end
  // slave shifter: sample on rising, change on falling, msb first
  always @(posedge clk) begin
    if (!reset_n) begin
      bitCnt    <= 3'h0;
      shiftIn   <= 8'h00;
      shiftOut  <= 8'h00;
      miso      <= 1'b0;
      misoOe_n  <= 1'b1;
      pushValid <= 1'b0;
      pushData  <= 8'h00;
      rxOverrun <= 1'b0;
    end else begin
      pushValid <= 1'b0;
      misoOe_n  <= ~(in_session(state) && !selHigh);
      if (txLoad) begin
        shiftOut <= txData;
      end
      if (!in_session(state) || selHigh) begin
        bitCnt <= 3'h0;
        miso   <= shiftOut[7];
      end else begin
        if (sckRise) begin
          shiftIn <= {shiftIn[6:0], mosiSync[1]};
          bitCnt  <= bitCnt + 1'b1;
          if (bitCnt == `ISSE_BIT_LAST) begin
            pushValid <= 1'b1;
            pushData  <= {shiftIn[6:0], mosiSync[1]};
          end
        end
        // a reply loaded inside the frame must show its msb before the first rising edge
        if (txLoad) begin
          miso <= txData[7];
        end
        if (sckFall && !txLoad) begin
          shiftOut <= {shiftOut[6:0], 1'b0};
          miso     <= shiftOut[6];
        end
      end
      // the serial link cannot stall, so a full queue drops the byte
      // judged at the push edge, so a pop just before it is not taken for a loss
      if (pushValid && !pushReady) begin
        rxOverrun <= 1'b1;
      end
      if (state == ST_RUN) begin
        rxOverrun <= 1'b0;
      end
    end
  end
  // sixteen bytes of slack absorb engine stalls; past that, bytes are lost
  isse_fifo #(
    .WIDTH (`ISSE_DATA_W),
    .DEPTH (`ISSE_FIFO_DEPTH),
    .AW    (`ISSE_FIFO_AW)
  ) rxFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );
endmodule // isse_isp_serial_entry_exit_sequencer

// *** isse_checker.sv ***
`timescale 1ns/1ps
module isse_checker (
  // clock and reset
  input wire       clk,
  input wire       reset_n,
  // pins
  input wire       rstPin,
  input wire       selectPin,
  input wire       sck,
  input wire       miso,
  input wire       misoOe_n,
  input wire       ioRelease,
  // stream and status
  input wire       rxValid,
  input wire       rxReady,
  input wire [7:0] rxData,
  input wire       programming
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rstLow4; !rstPin[*4]; endsequence
  sequence rstHigh5; rstPin[*5]; endsequence
  sequence sckRiseInFrame; $rose(sck) && !selectPin; endsequence
  io_release_a: assert property (rstLow4 |-> ioRelease) else $error("io not released");
  session_exit_a: assert property (rstHigh5 |-> !programming) else $error("still programming");
  entry_cause_a: assert property ($rose(programming) |-> $past(selectPin, 2) && $past(!rstPin, 2))
    else $error("entry without pins");
  miso_idle_a: assert property (!programming && !$past(programming) |-> misoOe_n)
    else $error("miso driven outside session");
  miso_hold_a: assert property (sckRiseInFrame |=> $stable(miso)[*6])
    else $error("miso moved while clock high");
  rx_hold_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("byte not held");
  frame_only_a: assert property ($rose(rxValid) |-> !selectPin) else $error("byte outside frame");
endmodule // isse_checker
bind isse_isp_serial_entry_exit_sequencer isse_checker chk_u (.clk, .reset_n, .rstPin, .selectPin, .sck,
  .miso, .misoOe_n, .ioRelease, .rxValid, .rxReady, .rxData, .programming);

// *** isse_prog_model.sv ***
`timescale 1ns/1ps
module isse_prog_model (
  // clock
  input wire clk,
  // device pins
  input wire miso,
  output reg rstPin,
  output reg selectPin,
  output reg sck,
  output reg mosi
);
  initial begin
    rstPin = 1'b0;
    selectPin = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // command waits in whole clocks; too long for the regression, kept for longer runs
  localparam integer WRITE_WAIT      = 312500;
  localparam integer AUTO_ERASE_WAIT = 625000;
  localparam integer CHIP_ERASE_WAIT = 937500;
  // every wait is counted in whole clocks
  task automatic wait_clk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task automatic enter(input integer w1, input integer w2);
    rstPin <= 1'b0;
    wait_clk(w1);
    selectPin <= 1'b1;
    wait_clk(w2);
    selectPin <= 1'b0;
    wait_clk(10);
  endtask
  // ten clocks a phase gives the 160 ns link period
  task automatic xfer(input [7:0] b, input integer n, output [7:0] r);
    integer i;
    r = 8'h00;
    for (i = 7; i > 7 - n; i = i - 1) begin
      mosi <= b[i];
      wait_clk(10);
      sck <= 1'b1;
      r[i] = miso;
      wait_clk(10);
      sck <= 1'b0;
    end
    wait_clk(10);
  endtask
  // a released line keeps no stale bit
  task automatic reframe;
    selectPin <= 1'b1;
    mosi <= ~mosi;
    wait_clk(10);
    selectPin <= 1'b0;
    wait_clk(10);
  endtask
  task automatic leave;
    wait_clk(10);
    selectPin <= 1'b1;
    mosi <= ~mosi;
    wait_clk(4);
    rstPin <= 1'b1;
    wait_clk(4);
  endtask
  // supply loss shows as the reset pin pulled down
  task automatic power_down;
    sck <= 1'b0;
    wait_clk(7);
    selectPin <= 1'b1;
    mosi <= ~mosi;
    wait_clk(4);
    wait_clk(8);
    rstPin <= 1'b0;
  endtask
endmodule // isse_prog_model

// *** isse_isp_serial_entry_exit_sequencer_bench.sv ***
`timescale 1ns/1ps
module isse_isp_serial_entry_exit_sequencer_bench;
  reg        clk, reset_n, rxReady, txLoad, resetPinEnableFuse, programEnableFuse;
  reg  [7:0] txData, got;
  wire       rstPin, selectPin, sck, mosi, miso, misoOe_n, ioRelease, rxValid, programming, rxOverrun;
  wire [7:0] rxData;
  integer    failures, comparisons, i;
  isse_isp_serial_entry_exit_sequencer dut_u (.clk, .reset_n, .rstPin, .selectPin, .sck, .mosi, .miso,
    .misoOe_n, .ioRelease, .resetPinEnableFuse, .programEnableFuse, .rxValid, .rxReady, .rxData, .txData,
    .txLoad, .programming, .rxOverrun);
  isse_prog_model prog_u (.clk, .miso, .rstPin, .selectPin, .sck, .mosi);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input string what, input [7:0] seen, input [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task pop(input [7:0] e);
    @(negedge clk);
    check("rxValid", rxValid, 1);
    check("rxData", rxData, e);
    @(posedge clk) rxReady <= 1'b1;
    @(posedge clk) rxReady <= 1'b0;
  endtask
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_powerup;
    prog_u.enter(1250, 12500);
    @(negedge clk) check("programming", programming, 1);
    check("misoOe_n", misoOe_n, 0);
    @(posedge clk) txLoad <= 1'b1;
    txData <= 8'hC3;
    @(posedge clk) txLoad <= 1'b0;
    prog_u.xfer(8'hA5, 8, got);
    check("reply", got, 8'hC3);
    pop(8'hA5);
    prog_u.leave;
    @(negedge clk) check("left", programming, 0);
    $display("powerup entry done");
  endtask
  // one setting alone must not open a running entry
  task t_refuse;
    @(posedge clk) resetPinEnableFuse <= 1'b1;
    prog_u.wait_clk(4);
    prog_u.enter(4, 16);
    @(negedge clk) check("refused", programming, 0);
    check("ioRelease", ioRelease, 1);
    prog_u.leave;
    $display("refused entry done");
  endtask
  // settings apply only once a session is closed, so they change in run state
  task t_fill;
    @(posedge clk) resetPinEnableFuse <= 1'b1;
    programEnableFuse <= 1'b1;
    prog_u.wait_clk(20);
    prog_u.enter(4, 16);
    @(negedge clk) check("entered", programming, 1);
    prog_u.xfer(8'hF0, 4, got);
    prog_u.reframe;
    for (i = 0; i < 17; i = i + 1)
      prog_u.xfer(8'h80 + i[7:0], 8, got);
    @(negedge clk) check("rxOverrun", rxOverrun, 1);
    for (i = 0; i < 16; i = i + 1)
      pop(8'h80 + i[7:0]);
    @(negedge clk) check("drained", rxValid, 0);
    prog_u.leave;
    prog_u.wait_clk(4);
    @(negedge clk) check("overrun cleared", rxOverrun, 0);
    check("ioRelease run", ioRelease, 0);
    @(posedge clk) prog_u.power_down;
    prog_u.wait_clk(3);
    @(negedge clk) check("ioRelease off", ioRelease, 1);
    $display("running entry and fill done");
  endtask
  initial begin
    reset_n = 1'b0;
    rxReady = 1'b0;
    txLoad = 1'b0;
    txData = 8'h00;
    resetPinEnableFuse = 1'b0;
    programEnableFuse = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_powerup;
    t_refuse;
    t_fill;
    print_verdict;
  end
  // whole run needs about 17200 clocks
  initial begin
    repeat (60000) @(posedge clk);
    failures = failures + 1;
    print_verdict;
  end
endmodule // isse_isp_serial_entry_exit_sequencer_bench
